// File: logic/status_led_pkg.sv
// Package with types and constants for the status indicator block
package status_led_pkg;

    // System clock rate and blink timebase
    localparam int CLK_HZ = 20000000;
    localparam int BLINK_HZ = 1;
    localparam int PERIOD_CYCLES = CLK_HZ / BLINK_HZ;
    localparam int HALF_PERCENT = 50;
    localparam int TENTH_PERCENT = 10;
    localparam int HALF_CYCLES = PERIOD_CYCLES * HALF_PERCENT / 100;
    localparam int TENTH_CYCLES = PERIOD_CYCLES * TENTH_PERCENT / 100;
    localparam int TB_WIDTH = 25;

    // Reset values
    localparam logic RESET_POWERED = 1'b0;
    localparam logic [TB_WIDTH-1:0] TIMEBASE_RESET = 25'h0000000;

    // Board power state
    typedef enum logic {
        POWER_OFF,
        POWER_ON
    } power_type;

    // Wireless link state
    typedef struct packed {
        logic advertising;
        logic connected;
    } link_type;

    // Charger state
    typedef struct packed {
        logic attached;
        logic charging;
    } charge_type;

    // Flash log state
    typedef struct packed {
        logic preparing;
        logic full;
        logic logging;
        logic closing;
    } flash_type;

    // Blink phases from the shared timebase
    typedef struct packed {
        logic half;
        logic tenth;
    } phase_type;

endpackage

// File: logic/blink_timebase.sv
// Free-running 1 Hz timebase producing the two blink phases
`timescale 1ns/1ps
`default_nettype none
module blink_timebase
    import status_led_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Phases
    output phase_type phase
);

    logic [TB_WIDTH-1:0] count;

    // Counter wraps once per second
    always_ff @(posedge clk) begin
        if (reset || count == TB_WIDTH'(PERIOD_CYCLES - 1)) begin
            count <= TIMEBASE_RESET;
        end else begin
            count <= count + 25'h0000001;
        end
    end

    // Both phases decode the same counter so the LEDs stay aligned
    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= '0;
        end else begin
            phase.half <= (count < TB_WIDTH'(HALF_CYCLES));
            phase.tenth <= (count < TB_WIDTH'(TENTH_CYCLES));
        end
    end

endmodule
`default_nettype wire

// File: logic/status_led_indicator.sv
// Top of the status indicator: power state and LED drive
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Advertising: green blinks 1Hz, half lit
// - Connected: green blinks 1Hz, tenth lit
// - Charger attached: red on charging, off done
// - Red steady while flash preparing or full
// - Logging: red blinks with green, else dark
// - Flash-log indication beats charge indication
// - Each power button press toggles power
// - Powered off: green held dark
// - Red lit while log closes at power-off
// - Attaching USB cable powers the board on
module status_led_indicator
    import status_led_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // Board state
    input wire link_type LINK,
    input wire charge_type CHARGE,
    input wire flash_type FLASH,
    input wire logic FLASH_ENABLED,
    input wire logic POWER_BUTTON,
    // Indicators
    output logic LED_GREEN,
    output logic LED_RED,
    output logic POWERED
);

    // Owner of the red LED; after RED_DARK, listed from highest priority down
    // Charge complete and an idle flash log both leave red dark
    typedef enum {
        RED_DARK,
        RED_CLOSING,
        RED_STEADY,
        RED_LOG,
        RED_CHARGE
    } red_cause_type;

    // Power state and its decoded forms
    power_type power;
    power_type next_power;
    logic powered_on;

    // Blink phases from the shared timebase
    // Both phases are lit at the start of every period
    phase_type phase;

    // Edge history of the pins and the events found in it
    logic button_prev;
    logic attached_prev;
    logic press;
    logic plug_in;

    // Link state that asks for a green blink
    logic link_up;

    // Red owner and the next values of the output registers
    red_cause_type red_cause;
    logic next_green;
    logic next_red;
    logic next_powered;

    // Level of a blink that follows the link state
    // Connected takes the short flash, advertising the even one
    function automatic logic blink_level(input link_type link_state, input phase_type phases);
        blink_level = link_state.connected ? phases.tenth : phases.half;
    endfunction

    // Flash prep or a full flash keeps red lit without blinking
    function automatic logic flash_steady(input flash_type flash_state);
        flash_steady = flash_state.preparing || flash_state.full;
    endfunction

    // Shared blink timebase, one counter for both LEDs
    // Red and green decode the same count, so their edges line up
    blink_timebase timebase (
        .clk(REF_CLK),
        .reset(RESET),
        .phase(phase)
    );

    // Button history
    // Idle level is low, so reset leaves no false press behind
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            button_prev <= 1'b0;
        end else begin
            button_prev <= POWER_BUTTON;
        end
    end

    // Cable history
    // A cable already present at reset release counts as a plug-in
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            attached_prev <= 1'b0;
        end else begin
            attached_prev <= CHARGE.attached;
        end
    end

    // Press event, one cycle long, so a held button toggles once
    assign press = POWER_BUTTON && !button_prev;

    // Plug-in event, one cycle long on the cable's rising edge
    assign plug_in = CHARGE.attached && !attached_prev;

    // Power state decision
    // A press wins over a plug-in in the same cycle and toggles
    always_comb begin
        next_power = power;
        if (press) begin
            next_power = (power == POWER_ON) ? POWER_OFF : POWER_ON;
        end else if (plug_in) begin
            next_power = POWER_ON;
        end
    end

    // Power state register
    // Power-on reset leaves the board switched off
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            power <= POWER_OFF;
        end else begin
            power <= next_power;
        end
    end

    // Decoded power state, read by the green pattern
    // Green follows it, one cycle behind the powered flag
    assign powered_on = (power == POWER_ON);

    // Powered flag matches the power register after each edge
    assign next_powered = (next_power == POWER_ON);

    // Link states that blink green; connected wins if both are up
    assign link_up = LINK.connected || LINK.advertising;

    // Green LED pattern
    // Off state holds green dark whatever the link does
    always_comb begin
        next_green = 1'b0;
        if (powered_on && link_up) begin
            next_green = blink_level(LINK, phase);
        end
    end

    // Red owner: closing first, then flash status, then charge
    // Closing is not gated by power, it shows after power-off
    always_comb begin
        red_cause = RED_DARK;
        if (FLASH.closing) begin
            red_cause = RED_CLOSING;
        end else if (FLASH_ENABLED) begin
            // Flash status replaces charge status
            if (flash_steady(FLASH)) begin
                red_cause = RED_STEADY;
            end else if (FLASH.logging) begin
                red_cause = RED_LOG;
            end
            // Enabled but idle leaves red dark, even on a charger
        end else if (flash_steady(FLASH)) begin
            red_cause = RED_STEADY;
        end else if (CHARGE.attached && CHARGE.charging) begin
            red_cause = RED_CHARGE;
        end
    end

    // Red level for its owner
    // Logging uses green's blink even while green is held dark
    always_comb begin
        next_red = 1'b0;
        unique case (red_cause)
            RED_DARK: next_red = 1'b0;
            RED_CLOSING: next_red = 1'b1;
            RED_STEADY: next_red = 1'b1;
            RED_LOG: next_red = blink_level(LINK, phase);
            RED_CHARGE: next_red = 1'b1;
            default: next_red = 1'b0;
        endcase
    end

    // Green output register
    // Every output comes straight from a flip-flop
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            LED_GREEN <= 1'b0;
        end else begin
            LED_GREEN <= next_green;
        end
    end

    // Red output register
    // Registered so an input change never glitches the LED
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            LED_RED <= 1'b0;
        end else begin
            LED_RED <= next_red;
        end
    end

    // Powered output register
    // Reset value follows the power-on state
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            POWERED <= RESET_POWERED;
        end else begin
            POWERED <= next_powered;
        end
    end

endmodule
`default_nettype wire

// File: tb/status_led_monitor.sv
// Checker for the status indicator ports
`timescale 1ns/1ps
`default_nettype none
module status_led_monitor
    import status_led_pkg::*;
(
    // Watched ports
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire link_type LINK,
    input wire charge_type CHARGE,
    input wire flash_type FLASH,
    input wire logic FLASH_ENABLED,
    input wire logic POWER_BUTTON,
    input wire logic LED_GREEN,
    input wire logic LED_RED,
    input wire logic POWERED
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // Logging only, shown while powered with the link up
    sequence log_held;
        (POWERED && FLASH_ENABLED && FLASH == 4'h2 && LINK != 2'h0)[*2];
    endsequence
    a_press_toggles: assert property ($rose(POWER_BUTTON) |-> ##2 POWERED != $past(POWERED, 2))
        else $error("power did not toggle on press");
    a_plug_powers: assert property ($rose(CHARGE.attached) && !$rose(POWER_BUTTON) |-> ##2 POWERED)
        else $error("plug-in did not power on");
    a_off_green: assert property (!POWERED ##1 !POWERED |-> !LED_GREEN)
        else $error("green lit while off");
    a_closing_red: assert property (FLASH.closing |=> LED_RED)
        else $error("red dark while log closes");
    a_prep_red: assert property (FLASH.preparing || FLASH.full |=> LED_RED)
        else $error("red dark while preparing or full");
    a_charge_red: assert property (CHARGE == 2'h3 && !FLASH_ENABLED |=> LED_RED)
        else $error("red dark while charging");
    a_done_dark: assert property (CHARGE == 2'h2 && !FLASH_ENABLED && FLASH == 4'h0 |=> !LED_RED)
        else $error("red lit after charge done");
    a_log_sync: assert property (log_held |-> LED_RED == LED_GREEN)
        else $error("red blink not in phase with green");
endmodule
bind status_led_indicator status_led_monitor mon (.REF_CLK(REF_CLK), .RESET(RESET),
    .LINK(LINK), .CHARGE(CHARGE), .FLASH(FLASH), .FLASH_ENABLED(FLASH_ENABLED),
    .POWER_BUTTON(POWER_BUTTON), .LED_GREEN(LED_GREEN), .LED_RED(LED_RED), .POWERED(POWERED));
`default_nettype wire

// File: tb/power_switch_model.sv
// User power switch that drives the button at falling edges
`timescale 1ns/1ps
`default_nettype none
module power_switch_model (
    // Clock and press request
    input wire logic clk,
    input wire logic press,
    // Button level
    output logic button
);
    // Button follows the request, clean of bounce
    always @(negedge clk) button <= press;
endmodule
`default_nettype wire

// File: tb/tb_status_led_indicator.sv
// Testbench for the status indicator
`timescale 1ns/1ps
`default_nettype none
module tb_status_led_indicator
    import status_led_pkg::*;
;
    logic clk = 0, rst = 1, press = 0, btn, green, red, pwr, fen = 0, ep = 0;
    link_type link = '0;
    charge_type chg = '0;
    flash_type fl = '0;
    logic [31:0] s = 32'hd7ab9fb6;
    int miscompares = 0, check_count = 0;
    // Clock and instances
    initial forever #25 clk = ~clk;
    status_led_indicator DUT (.REF_CLK(clk), .RESET(rst), .LINK(link), .CHARGE(chg), .FLASH(fl),
        .FLASH_ENABLED(fen), .POWER_BUTTON(btn), .LED_GREEN(green), .LED_RED(red), .POWERED(pwr));
    power_switch_model button_model (.clk(clk), .press(press), .button(btn));
    // Red level early in a period, when both blink phases are lit
    function automatic logic exp_red(flash_type f, charge_type c, logic e);
        if (f.closing || f.preparing || f.full) return 1'b1;
        if (e) return f.logging;
        return c.attached && c.charging;
    endfunction
    task automatic check(logic seen, logic want);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: led or power level", $time);
        end
    endtask
    task automatic step(link_type l, charge_type c, flash_type f, logic e);
        @(negedge clk);
        if (c.attached && !chg.attached) ep = 1'b1;
        link = l;
        chg = c;
        fl = f;
        fen = e;
        repeat (3) @(negedge clk);
        check(pwr, ep);
        check(green, ep && l != 2'h0);
        check(red, exp_red(f, c, e));
    endtask
    task automatic push;
        @(negedge clk) press = 1'b1;
        repeat (2) @(negedge clk);
        press = 1'b0;
        ep = !ep;
        repeat (3) @(negedge clk);
        check(pwr, ep);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Directed corners, then random board states with presses
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        push;
        step(2'h2, 2'h0, 4'h0, 1'b0);
        step(2'h1, 2'h3, 4'h0, 1'b0);
        step(2'h1, 2'h2, 4'h0, 1'b0);
        step(2'h2, 2'h3, 4'h2, 1'b1);
        step(2'h2, 2'h3, 4'h0, 1'b1);
        step(2'h0, 2'h0, 4'h8, 1'b1);
        step(2'h0, 2'h0, 4'h4, 1'b0);
        push;
        step(2'h2, 2'h0, 4'h1, 1'b0);
        $display("directed test done");
        // Reset in mid-run: board off, green dark, and with no cable present it stays off
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        check(pwr, 1'b0);
        check(green, 1'b0);
        rst = 1'b0;
        ep = chg.attached;
        repeat (2) @(negedge clk);
        check(pwr, ep);
        $display("reset test done");
        repeat (60) begin
            s ^= s << 13;
            s ^= s >> 17;
            s ^= s << 5;
            if (s[9]) push;
            step(s[1:0], s[3:2], s[7:4], s[8]);
        end
        $display("random test done");
        final_report;
    end
    // Watchdog against a hang
    initial begin
        #300000;
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire
